// *** paged_flash_pkg.sv ***
// Purpose: Shared constants for the paged serial flash port.
// Assumes: Instruction codes are local choices, not fixed by any standard.
// Notes:   Array geometry and status layout live here too.

package paged_flash_pkg;

   // ----------------------------------------
   // Array geometry
   // ----------------------------------------
   localparam int ADDR_W           = 19;
   localparam int PAGE_W           = 11;
   localparam int PAGE_BYTES       = 256;
   localparam int PAGES_PER_SECTOR = 256;
   localparam int SECTOR_COUNT     = 8;
   localparam int ARRAY_BYTES      = SECTOR_COUNT * PAGES_PER_SECTOR * PAGE_BYTES;
   localparam logic [PAGE_W-1:0] PROTECT_PAGES = 11'h100;

   // ----------------------------------------
   // Frame layout
   // ----------------------------------------
   localparam logic [2:0] HDR_BYTES  = 3'h4;
   localparam logic [2:0] DATA_SEEN  = 3'h5;
   localparam logic [2:0] BIT_LAST   = 3'h7;

   // ----------------------------------------
   // Status byte
   // ----------------------------------------
   localparam int STATUS_BUSY_BIT  = 0;
   localparam int STATUS_LATCH_BIT = 1;
   localparam logic [5:0] STATUS_ZERO = 6'h00;

   // ----------------------------------------
   // Instruction codes
   // ----------------------------------------
   localparam logic [7:0] OP_MODIFY_UNLOCK = 8'h11;
   localparam logic [7:0] OP_MODIFY_LOCK   = 8'h12;
   localparam logic [7:0] OP_STATUS_READ   = 8'h13;
   localparam logic [7:0] OP_PAGE_REWRITE  = 8'h14;
   localparam logic [7:0] OP_PAGE_BURN     = 8'h15;
   localparam logic [7:0] OP_PAGE_CLEAR    = 8'h16;
   localparam logic [7:0] OP_BLOCK_CLEAR   = 8'h17;
   localparam logic [7:0] OP_DEEP_SLEEP    = 8'h18;
   localparam logic [7:0] OP_WAKE_UP       = 8'h19;

   // ----------------------------------------
   // Array operation kinds and sequencer states
   // ----------------------------------------
   localparam logic [1:0] KIND_PAGE_ERASE   = 2'h0;
   localparam logic [1:0] KIND_PAGE_PROGRAM = 2'h1;
   localparam logic [1:0] KIND_SECTOR_ERASE = 2'h2;

   typedef enum logic [3:0] {
      SEQ_IDLE   = 4'h1,
      SEQ_ERASE  = 4'h2,
      SEQ_PROG   = 4'h4,
      SEQ_SINGLE = 4'h8
   } seq_state_t;

endpackage

// *** paged_flash_spi_port.sv ***
// Purpose: Serial bus slave front end of a paged serial flash array.
// Assumes: The array behind opStart/wrValid reports completion on opDone.
// Notes:   Serial logic runs on sclk; control logic runs on clk.

`timescale 1ns/10ps

// What this block does (RQ13 is left to the master)
// RQ1: Serial output changes on falling clock edges
// RQ2: Input bits sampled on rising clock edges
// RQ3: Deselected device floats its serial output
// RQ4: Standby only after internal cycles finish
// RQ5: Select low means selected, active power
// RQ6: First instruction needs a select falling edge
// RQ7: Reset pin low resets when idle, outputs float
// RQ8: Running internal cycle ignores reset pin
// RQ9: Reset pin high means normal operation
// RQ10: Protect low blocks changes to lowest pages
// RQ11: Protect high leaves lowest pages modifiable
// RQ12: Supports clock modes 0,0 and 1,1
// RQ13: Master parks clock per chosen polarity
// RQ14: Page write accepts 1 to 256 bytes
// RQ15: Page rewrite erases then programs the page
// RQ16: Eight sectors of 256 pages, 256 bytes
// RQ17: Erase one page or one whole sector
// RQ18: Status: busy bit0, latch bit1, rest zero
// RQ19: Modify instructions need whole bytes only
// RQ20: Unlock first; latch clears on reset, completion
// RQ21: Deep sleep ignores all but wake up
// RQ22: Bytes go MSB first, one frame each
module paged_flash_spi_port
   import paged_flash_pkg::*;
(
   // System
   input  wire logic              clk,
   input  wire logic              rst,
   // Serial link pins
   input  wire logic              sclk,
   input  wire logic              selN,
   input  wire logic              dataIn,
   output logic                   dataOut,
   output logic                   dataOutEn,
   // Control pins
   input  wire logic              resetPinN,
   input  wire logic              writeProtN,
   // Array operation side
   output logic                   opStart,
   output logic [1:0]             opKind,
   output logic [PAGE_W-1:0]      opPage,
   input  wire logic              opDone,
   output logic                   wrValid,
   output logic [7:0]             wrColumn,
   output logic [7:0]             wrData,
   // State
   output logic                   busyFlag,
   output logic                   modifyPermitLatch,
   output logic                   powerActive,
   output logic                   powerStandby,
   output logic                   powerDeepSleep,
   output logic                   resetActive
);

   if (ARRAY_BYTES != 524288) begin : g_geometry_check
      $error("array geometry does not match the address width");
   end

   // ----------------------------------------
   // Link domain (sclk)
   // ----------------------------------------
   // Counters clear whenever select is high; the frame summary does not, so
   // the clk side can still read it after the frame has closed.
   logic              linkRst;
   logic [2:0]        bitIdx_q;
   logic [2:0]        byteCnt_q;
   logic [6:0]        shiftIn_q;
   logic [7:0]        sumOp_q;
   logic [ADDR_W-1:0] sumAddr_q;
   logic [2:0]        sumBitIdx_q;
   logic [2:0]        sumByteCnt_q;
   logic [7:0]        dataHold_q;
   logic              byteTgl_q;
   logic              frameTgl_q;
   logic [1:0]        statS1_q;
   logic [1:0]        statS2_q;
   logic              outBit_q;
   logic              drive_q;

   wire       byteDone   = (bitIdx_q == BIT_LAST);
   wire [7:0] newByte    = {shiftIn_q, dataIn};
   wire [2:0] bitNext    = bitIdx_q + 3'h1;
   wire       cntSat     = (byteCnt_q == DATA_SEEN);
   wire [2:0] byteNext   = (byteDone && !cntSat) ? byteCnt_q + 3'h1 : byteCnt_q;
   wire       frameFirst = (bitIdx_q == 3'h0) && (byteCnt_q == 3'h0);
   wire       progOp     = (sumOp_q == OP_PAGE_REWRITE) || (sumOp_q == OP_PAGE_BURN);
   wire [7:0] statusByte = {STATUS_ZERO, statS2_q};                 // see RQ18
   wire       statusFrame = (byteCnt_q != 3'h0) && (sumOp_q == OP_STATUS_READ);

   assign linkRst = rst | selN;                                    // see RQ3

   always_ff @(posedge sclk or posedge linkRst) begin
      if (linkRst) begin
         bitIdx_q  <= 3'h0;
         byteCnt_q <= 3'h0;
         shiftIn_q <= 7'h00;
      end else begin
         bitIdx_q  <= bitNext;                                     // see RQ2
         byteCnt_q <= byteNext;
         shiftIn_q <= newByte[6:0];                                // see RQ22
      end
   end

   // Frame summary, held across deselect
   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         sumBitIdx_q  <= 3'h0;
         sumByteCnt_q <= 3'h0;
         frameTgl_q   <= 1'b0;
      end else if (!selN) begin
         // A parked-clock edge between frames is not a frame bit
         sumBitIdx_q  <= bitNext;
         sumByteCnt_q <= byteNext;
         if (frameFirst) begin
            frameTgl_q <= ~frameTgl_q;
         end
      end
   end

   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         sumOp_q    <= 8'h00;
         sumAddr_q  <= '0;
         dataHold_q <= 8'h00;
         byteTgl_q  <= 1'b0;
      end else if (byteDone) begin
         case (byteCnt_q)
            3'h0:    sumOp_q <= newByte;
            3'h1:    sumAddr_q[ADDR_W-1:16] <= newByte[ADDR_W-17:0];  // see RQ16
            3'h2:    sumAddr_q[15:8] <= newByte;
            3'h3:    sumAddr_q[7:0] <= newByte;
            default: begin
               dataHold_q <= newByte;
               byteTgl_q  <= byteTgl_q ^ progOp;
            end
         endcase
      end
   end

   // Status bits enter the link domain through two flops
   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         statS1_q <= 2'h0;
         statS2_q <= 2'h0;
      end else begin
         statS1_q <= {modifyPermitLatch, busyFlag};
         statS2_q <= statS1_q;
      end
   end

   // Falling edge drive works for both clock polarities
   always_ff @(negedge sclk or posedge linkRst) begin
      if (linkRst) begin
         outBit_q <= 1'b0;
         drive_q  <= 1'b0;
      end else begin
         outBit_q <= statusByte[BIT_LAST - bitIdx_q];              // see RQ1, RQ12
         drive_q  <= statusFrame;
      end
   end

   // ----------------------------------------
   // Pin synchronisers (clk)
   // ----------------------------------------
   logic [2:0] selS_q;
   logic [1:0] rstPinS_q;
   logic [1:0] protS_q;
   logic [2:0] byteTglS_q;
   logic [1:0] frameTglS_q;
   logic       frameUsed_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         // Idle pin levels, so release gives no false edge
         selS_q      <= 3'h7;
         rstPinS_q   <= 2'h3;
         protS_q     <= 2'h0;
         byteTglS_q  <= 3'h0;
         frameTglS_q <= 2'h0;
      end else begin
         selS_q      <= {selS_q[1:0], selN};
         rstPinS_q   <= {rstPinS_q[0], resetPinN};
         protS_q     <= {protS_q[0], writeProtN};
         byteTglS_q  <= {byteTglS_q[1:0], byteTgl_q};
         frameTglS_q <= {frameTglS_q[0], frameTgl_q};
      end
   end

   wire selHigh  = selS_q[1];
   wire selRise  = selS_q[1] & ~selS_q[2];
   wire selFall  = ~selS_q[1] & selS_q[2];
   wire byteEvt  = byteTglS_q[1] ^ byteTglS_q[2];
   wire newFrame = frameTglS_q[1] ^ frameUsed_q;

   // ----------------------------------------
   // Control state (clk)
   // ----------------------------------------
   seq_state_t  state_q;
   seq_state_t  state_d;
   logic        armed_q;
   logic        latch_q;
   logic        sleep_q;
   logic        resetMode_q;
   logic [7:0]  colCnt_q;
   logic        opStart_q;
   logic [1:0]  opKind_q;
   logic [PAGE_W-1:0] opPage_q;
   logic        wrValid_q;
   logic [7:0]  wrColumn_q;
   logic [7:0]  wrData_q;

   wire idle = (state_q == SEQ_IDLE);

   // Frame decode at deselect
   wire [PAGE_W-1:0] page = sumAddr_q[ADDR_W-1:8];
   wire enterReset = ~rstPinS_q[1] & (idle | resetMode_q);         // see RQ7, RQ8
   wire frameEnd   = selRise & newFrame & armed_q & ~resetMode_q & ~enterReset; // see RQ6, RQ9
   wire awakeEnd   = frameEnd & ~sleep_q;                          // see RQ21
   wire wholeBytes = (sumBitIdx_q == 3'h0);                         // see RQ19
   wire hdrSeen    = (sumByteCnt_q >= HDR_BYTES);
   wire dataSeen   = (sumByteCnt_q == DATA_SEEN);                   // see RQ14
   wire protHit    = ~protS_q[1] && (page < PROTECT_PAGES);         // see RQ10, RQ11
   wire isRewrite  = (sumOp_q == OP_PAGE_REWRITE);
   wire isBurn     = (sumOp_q == OP_PAGE_BURN);
   wire isPgClear  = (sumOp_q == OP_PAGE_CLEAR);
   wire isBlkClear = (sumOp_q == OP_BLOCK_CLEAR);                   // see RQ17
   wire needsData  = isRewrite | isBurn;
   wire isModify   = needsData | isPgClear | isBlkClear;
   wire modifyOk   = awakeEnd & isModify & idle & latch_q & wholeBytes & hdrSeen
                     & ~protHit & (dataSeen | ~needsData);          // see RQ20
   wire unlockHit  = awakeEnd & (sumOp_q == OP_MODIFY_UNLOCK) & (sumByteCnt_q != 3'h0);
   wire lockHit    = awakeEnd & (sumOp_q == OP_MODIFY_LOCK) & (sumByteCnt_q != 3'h0);
   wire sleepHit   = awakeEnd & (sumOp_q == OP_DEEP_SLEEP) & idle;
   wire wakeHit    = frameEnd & sleep_q & (sumOp_q == OP_WAKE_UP);
   wire cycleEnd   = opDone & ((state_q == SEQ_PROG) | (state_q == SEQ_SINGLE));

   // Data bytes only reach the array for a frame that may still execute
   wire wrAllow    = armed_q & ~resetMode_q & ~sleep_q & idle & latch_q & ~protHit;

   // Sequencer next state: rewrite is an erase phase then a program phase
   always_comb begin
      state_d = state_q;
      case (state_q)
         SEQ_IDLE: begin
            if (modifyOk && isRewrite) begin
               state_d = SEQ_ERASE;                                // see RQ15
            end else if (modifyOk) begin
               state_d = SEQ_SINGLE;
            end
         end
         SEQ_ERASE: begin
            if (opDone) begin
               state_d = SEQ_PROG;                                 // see RQ15
            end
         end
         SEQ_PROG,
         SEQ_SINGLE: begin
            if (opDone) begin
               state_d = SEQ_IDLE;
            end
         end
         default: state_d = SEQ_IDLE;
      endcase
   end

   wire startErasePh = modifyOk & (isRewrite | isPgClear);
   wire startProgPh  = (modifyOk & isBurn) | ((state_q == SEQ_ERASE) & opDone);
   wire startSector  = modifyOk & isBlkClear;
   wire anyStart     = startErasePh | startProgPh | startSector;
   wire [1:0] kindD  = startSector ? KIND_SECTOR_ERASE :
                       startProgPh ? KIND_PAGE_PROGRAM : KIND_PAGE_ERASE;

   // Running cycle is not touched by the reset pin; reset mode waits for idle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= SEQ_IDLE;
      end else begin
         state_q <= state_d;                                       // see RQ8
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         resetMode_q <= 1'b0;
         armed_q     <= 1'b0;
         frameUsed_q <= 1'b0;
      end else begin
         resetMode_q <= enterReset;                                 // see RQ7, RQ8
         if (selFall) begin
            armed_q <= 1'b1;                                       // see RQ6
         end
         if (selRise) begin
            frameUsed_q <= frameTglS_q[1];
         end
      end
   end

   // Set wins over a completion clear in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         latch_q <= 1'b0;
      end else if (unlockHit) begin
         latch_q <= 1'b1;                                          // see RQ20
      end else if (enterReset || lockHit || cycleEnd || modifyOk) begin
         latch_q <= 1'b0;                                          // see RQ20
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sleep_q <= 1'b0;
      end else if (sleepHit) begin
         sleep_q <= 1'b1;
      end else if (wakeHit || resetMode_q) begin
         sleep_q <= 1'b0;                                          // see RQ21
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         opStart_q <= 1'b0;
         opKind_q  <= KIND_PAGE_ERASE;
         opPage_q  <= '0;
      end else begin
         opStart_q <= anyStart;
         if (anyStart) begin
            opKind_q <= kindD;
            opPage_q <= page;                                      // see RQ16
         end
      end
   end

   // Column wraps inside the page, as the page buffer does
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         colCnt_q   <= 8'h00;
         wrValid_q  <= 1'b0;
         wrColumn_q <= 8'h00;
         wrData_q   <= 8'h00;
      end else begin
         wrValid_q <= byteEvt & wrAllow;                           // see RQ14
         if (selFall) begin
            colCnt_q <= 8'h00;
         end else if (byteEvt) begin
            colCnt_q   <= colCnt_q + 8'h01;
            wrColumn_q <= sumAddr_q[7:0] + colCnt_q;
            wrData_q   <= dataHold_q;
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign dataOut           = outBit_q;
   assign dataOutEn         = drive_q & ~selN & ~resetMode_q & ~sleep_q;  // see RQ3, RQ7
   assign opStart           = opStart_q;
   assign opKind            = opKind_q;
   assign opPage            = opPage_q;
   assign wrValid           = wrValid_q;
   assign wrColumn          = wrColumn_q;
   assign wrData            = wrData_q;
   assign busyFlag          = ~idle;
   assign modifyPermitLatch = latch_q;
   assign powerActive       = ~selHigh | ~idle;                    // see RQ5
   assign powerStandby      = selHigh & idle & ~sleep_q;           // see RQ4
   assign powerDeepSleep    = sleep_q & idle & selHigh;
   assign resetActive       = resetMode_q;

endmodule

// *** paged_flash_spi_port_assertions.sv ***
// Purpose: Port-level checks for the paged flash serial port.
// Assumes: Serial pins change away from the clk rising edge.
// Notes:   Serial pins are watched as levels in the clk domain.
`timescale 1ns/10ps
module paged_flash_spi_port_assertions
   import paged_flash_pkg::*;
(
   // System
   input wire logic              clk,
   input wire logic              rst,
   // Serial and control pins
   input wire logic              sclk,
   input wire logic              selN,
   input wire logic              dataIn,
   input wire logic              dataOut,
   input wire logic              dataOutEn,
   input wire logic              resetPinN,
   input wire logic              writeProtN,
   // Array side and state
   input wire logic              opStart,
   input wire logic [1:0]        opKind,
   input wire logic [PAGE_W-1:0] opPage,
   input wire logic              opDone,
   input wire logic              wrValid,
   input wire logic [7:0]        wrColumn,
   input wire logic [7:0]        wrData,
   input wire logic              busyFlag,
   input wire logic              modifyPermitLatch,
   input wire logic              powerActive,
   input wire logic              powerStandby,
   input wire logic              powerDeepSleep,
   input wire logic              resetActive
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_float_deselect: assert property (selN |-> !dataOutEn)
      else $error("output driven while deselected");
   a_busy_start: assert property (opStart |=> busyFlag)
      else $error("busy not set after start");
   a_busy_holds: assert property (busyFlag && !opDone |=> busyFlag)
      else $error("busy dropped without done");
   a_single_op: assert property (opStart |-> opKind != 2'h3 ##1 !opStart)
      else $error("bad operation start");
   a_latch_clear: assert property (opStart |-> ##[0:1] !modifyPermitLatch)
      else $error("permit latch kept after start");
   a_standby_idle: assert property (powerStandby |-> !busyFlag && !powerDeepSleep)
      else $error("standby while busy");
   a_reset_waits: assert property ($rose(resetActive) |-> !busyFlag && !$past(resetPinN))
      else $error("reset entered while busy");
   a_reset_float: assert property (resetActive |-> !dataOutEn && !modifyPermitLatch && !opStart)
      else $error("activity during reset mode");
   a_sleep_quiet: assert property (powerDeepSleep |->
      !opStart && !$rose(modifyPermitLatch))
      else $error("activity during deep sleep");
   a_protect_low: assert property (opStart && ((opKind == KIND_SECTOR_ERASE) ?
      (opPage[10:8] == 3'h0) : (opPage < PROTECT_PAGES)) |-> writeProtN)
      else $error("protected page modified");

   c_burn: cover property (opStart && opKind == KIND_PAGE_PROGRAM);
   c_sector: cover property (opStart && opKind == KIND_SECTOR_ERASE);
   c_reset: cover property ($rose(resetActive));
   c_sleep: cover property ($rose(powerDeepSleep));
endmodule

bind paged_flash_spi_port paged_flash_spi_port_assertions paged_flash_spi_port_assertions_i (
   .clk(clk), .rst(rst), .sclk(sclk), .selN(selN), .dataIn(dataIn), .dataOut(dataOut),
   .dataOutEn(dataOutEn), .resetPinN(resetPinN), .writeProtN(writeProtN),
   .opStart(opStart), .opKind(opKind), .opPage(opPage), .opDone(opDone),
   .wrValid(wrValid), .wrColumn(wrColumn), .wrData(wrData), .busyFlag(busyFlag),
   .modifyPermitLatch(modifyPermitLatch), .powerActive(powerActive),
   .powerStandby(powerStandby), .powerDeepSleep(powerDeepSleep), .resetActive(resetActive)
);

// *** spi_host_model.sv ***
// Purpose: Serial bus master model facing the flash port.
// Assumes: 48 ns serial clock, toggled outside frames only to park at a new polarity.
// Notes:   Last received byte is left in rxByte.
`timescale 1ns/10ps
module spi_host_model (
   // Reference for frame start
   input  wire logic clk,
   // Serial pins
   output logic      sclk,
   output logic      selN,
   output logic      dataIn,
   input  wire logic dataOut,
   input  wire logic dataOutEn
);
   logic [7:0] txBuf [0:7];
   logic [7:0] rxByte;

   initial begin
      sclk = 1'b0;
      selN = 1'b1;
      dataIn = 1'b0;
      rxByte = 8'h00;
   end

   // Extra bits of 1 model a torn last byte
   task automatic frame(input int nBytes, input int extra, input logic cpol);
      int i;
      sclk = cpol;
      @(negedge clk);
      selN = 1'b0;
      for (i = 0; i < nBytes * 8 + extra; i++) begin
         #24;
         sclk = 1'b0;
         dataIn = (i < nBytes * 8) ? txBuf[i / 8][7 - i % 8] : 1'b1;
         #24;
         sclk = 1'b1;
         rxByte = {rxByte[6:0], (dataOutEn === 1'b1) ? dataOut : 1'bx};
      end
      #24;
      sclk = cpol;
      dataIn = ~dataIn;
      #24;
      selN = 1'b1;
      // Deselect gap lets the port read the frame summary
      repeat (6) @(negedge clk);
   endtask
endmodule

// *** test_paged_flash_spi_port.sv ***
// Purpose: Self-checking bench for the paged flash serial port.
// Assumes: Array completion is modelled by a delayed opDone pulse.
// Notes:   Control inputs change on the falling clk edge; serial pins follow the host model's timing.
`timescale 1ns/10ps
module test_paged_flash_spi_port;
   import paged_flash_pkg::*;
   logic clk, rst, sclk, selN, dataIn, dataOut, dataOutEn, resetPinN, writeProtN;
   logic opStart, opDone, wrValid, busyFlag, modifyPermitLatch;
   logic powerActive, powerStandby, powerDeepSleep, resetActive, mode, prevKind0;
   logic [1:0]        opKind, lastKind, prevKind;
   logic [PAGE_W-1:0] opPage, lastPage;
   logic [7:0]        wrColumn, wrData, lastCol, lastData;
   int                badCount, checked, opCount, wrCount, doneDelay, cycles;

   paged_flash_spi_port paged_flash_spi_port_i (.clk(clk), .rst(rst), .sclk(sclk),
      .selN(selN), .dataIn(dataIn), .dataOut(dataOut), .dataOutEn(dataOutEn),
      .resetPinN(resetPinN), .writeProtN(writeProtN), .opStart(opStart), .opKind(opKind),
      .opPage(opPage), .opDone(opDone), .wrValid(wrValid), .wrColumn(wrColumn),
      .wrData(wrData), .busyFlag(busyFlag), .modifyPermitLatch(modifyPermitLatch),
      .powerActive(powerActive), .powerStandby(powerStandby),
      .powerDeepSleep(powerDeepSleep), .resetActive(resetActive));
   spi_host_model spi_host_model_i (.clk(clk), .sclk(sclk), .selN(selN), .dataIn(dataIn),
      .dataOut(dataOut), .dataOutEn(dataOutEn));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ----------------------------------------
   // Array stand-in and monitors
   // ----------------------------------------
   initial begin
      opDone = 1'b0;
      forever begin
         @(posedge clk iff opStart === 1'b1);
         opCount++;
         prevKind = lastKind;
         lastKind = opKind;
         lastPage = opPage;
         repeat (doneDelay) @(negedge clk);
         opDone = 1'b1;
         @(negedge clk);
         opDone = 1'b0;
      end
   end
   always @(posedge clk) begin
      cycles++;
      if (wrValid === 1'b1) begin
         wrCount++;
         lastCol = wrColumn;
         lastData = wrData;
      end
      if (cycles == 20000) begin
         badCount++;
         print_verdict();
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         badCount++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int n, input int extra);
      int k;
      spi_host_model_i.txBuf[0] = op;
      spi_host_model_i.txBuf[1] = a[23:16];
      spi_host_model_i.txBuf[2] = a[15:8];
      spi_host_model_i.txBuf[3] = a[7:0];
      for (k = 0; k < 4; k++) begin
         spi_host_model_i.txBuf[4 + k] = 8'hA0 + 8'(k);
      end
      spi_host_model_i.frame(n, extra, mode);
   endtask
   task automatic status(input logic [7:0] exp);
      cmd(OP_STATUS_READ, 24'h000000, 2, 0);
      check({8'h00, spi_host_model_i.rxByte}, {8'h00, exp});
   endtask
   task automatic idle();
      int i;
      for (i = 0; i < 2000 && busyFlag !== 1'b0; i++) begin
         @(negedge clk);
      end
   endtask
   task print_verdict;
      $display("Counts: checked %0d, mismatches %0d", checked, badCount);
      if (badCount == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      resetPinN = 1'b1;
      writeProtN = 1'b1;
      mode = 1'b0;
      doneDelay = 20;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      check(dataOutEn, 1'b0);
      status(8'h00);
      cmd(OP_MODIFY_UNLOCK, 24'h000000, 1, 0);
      mode = 1'b1;
      status(8'h02);
      doneDelay = 300;
      cmd(OP_PAGE_BURN, 24'h0100FE, 6, 0);
      check(16'(wrCount), 16'h0002);
      check(lastCol, 8'hFF);
      check(lastData, 8'hA1);
      check(lastKind, KIND_PAGE_PROGRAM);
      check(lastPage, 11'h100);
      status(8'h01);
      idle();
      status(8'h00);
      mode = 1'b0;
      doneDelay = 20;
      cmd(OP_MODIFY_UNLOCK, 24'h000000, 1, 0);
      cmd(OP_PAGE_REWRITE, 24'h000510, 5, 0);
      idle();
      check(prevKind, KIND_PAGE_ERASE);
      check({lastKind, lastPage}, {KIND_PAGE_PROGRAM, 11'h005});
      writeProtN = 1'b0;
      cmd(OP_MODIFY_UNLOCK, 24'h000000, 1, 0);
      cmd(OP_PAGE_BURN, 24'h00FF00, 5, 0);
      cmd(OP_BLOCK_CLEAR, 24'h000000, 4, 0);
      check(16'(opCount), 16'h0003);
      cmd(OP_PAGE_CLEAR, 24'h010000, 4, 0);
      idle();
      check({lastKind, lastPage}, {KIND_PAGE_ERASE, 11'h100});
      writeProtN = 1'b1;
      cmd(OP_MODIFY_UNLOCK, 24'h000000, 1, 0);
      cmd(OP_BLOCK_CLEAR, 24'h070000, 4, 0);
      idle();
      check({lastKind, lastPage[10:8]}, {KIND_SECTOR_ERASE, 3'h7});
      cmd(OP_MODIFY_UNLOCK, 24'h000000, 1, 0);
      cmd(OP_PAGE_CLEAR, 24'h020000, 4, 3);
      check(16'(opCount), 16'h0005);
      cmd(OP_MODIFY_LOCK, 24'h000000, 1, 0);
      cmd(OP_PAGE_CLEAR, 24'h020000, 4, 0);
      check(16'(opCount), 16'h0005);
      doneDelay = 200;
      cmd(OP_MODIFY_UNLOCK, 24'h000000, 1, 0);
      cmd(OP_PAGE_CLEAR, 24'h020000, 4, 0);
      resetPinN = 1'b0;
      repeat (10) @(negedge clk);
      check({resetActive, busyFlag}, 2'h1);
      check(powerActive, 1'b1);
      idle();
      repeat (4) @(negedge clk);
      check({resetActive, dataOutEn}, 2'h2);
      resetPinN = 1'b1;
      repeat (6) @(negedge clk);
      status(8'h00);
      cmd(OP_DEEP_SLEEP, 24'h000000, 1, 0);
      cmd(OP_MODIFY_UNLOCK, 24'h000000, 1, 0);
      check({powerDeepSleep, modifyPermitLatch}, 2'h2);
      cmd(OP_WAKE_UP, 24'h000000, 1, 0);
      check({powerDeepSleep, powerStandby}, 2'h1);
      check(powerActive, 1'b0);
      print_verdict();
   end
endmodule
